// ### inc/pfs_pkg.sv
// constants and types for the port e pin function select block
package pfs_pkg;
  localparam int PIN_COUNT = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int MODE_W = 3;
  localparam int PRIO_W = 4;
  localparam int FIELD_STRIDE = 4;
  // register addresses
  localparam logic [3:0] ADDR_DIRECTION = 4'h0;
  localparam logic [3:0] ADDR_SEL_UPPER = 4'h4;
  localparam logic [3:0] ADDR_SEL_MIDDLE = 4'h8;
  localparam logic [3:0] ADDR_PRIORITY = 4'hc;
  localparam logic [3:0] ADDR_PIN_STATE = 4'h2;
  // reset values
  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic [15:0] RST_PRIORITY = 16'h0000;
  // writable bits of a function select register, reserved bits cleared
  localparam logic [15:0] SEL_WRITE_MASK = 16'h7777;
  // mode codes
  localparam logic [2:0] MODE_PORT = 3'h0;
  localparam logic [2:0] MODE_SYNC_CLOCK = 3'h2;
  localparam logic [2:0] MODE_RECEIVE = 3'h3;
  // field positions
  localparam int PIN11_FIELD_LSB = 12;
  localparam int PIN6_FIELD_LSB = 8;
  localparam int SERIAL_PRIO_LSB = 0;
  localparam int PIN_RX = 11;
  localparam int PIN_SCK = 6;
  localparam int MUX_FIRST = 4;
  localparam int MUX_LAST = 11;
  // pin source selection
  typedef enum logic [1:0] {PFS_SRC_PORT, PFS_SRC_SCK, PFS_SRC_RX, PFS_SRC_OFF} pfs_src_t;
endpackage : pfs_pkg

// ### inc/pfs_mode_if.sv
// interface carrying the direction and select register values from the register file to the mux
`timescale 1ns/100ps
interface pfs_mode_if;
  logic [15:0] direction;
  logic [15:0] sel_upper;
  logic [15:0] sel_middle;
  modport regs (output direction, output sel_upper, output sel_middle);
  modport mux (input direction, input sel_upper, input sel_middle);
endinterface : pfs_mode_if

// ### src/pfs_pin_mux.sv
// per pin function decode and routing
`timescale 1ns/100ps
module pfs_pin_mux (
  // configuration
  pfs_mode_if.mux cfg,
  // port side
  input wire logic [15:0] i_port_out,
  input wire logic [15:0] i_pin_sync,
  // serial side
  input wire logic i_sck_out,
  input wire logic i_sck_oe,
  // pins
  output logic [15:0] o_pin_out,
  output logic [15:0] o_pin_oe,
  output logic o_rx_data,
  output logic o_sck_in
);
  // four pin fields per select register, upper register starts three pins below the last
  localparam int FIELDS_PER_REG = pfs_pkg::DATA_W / pfs_pkg::FIELD_STRIDE;
  localparam int UPPER_FIRST = pfs_pkg::MUX_LAST + 1 - FIELDS_PER_REG;
  logic [pfs_pkg::MODE_W-1:0] mode [pfs_pkg::PIN_COUNT];

  // per pin mode and routing
  genvar g;
  generate
    for (g = 0; g < pfs_pkg::PIN_COUNT; g++) begin : g_pin
      if (g >= pfs_pkg::MUX_FIRST && g <= pfs_pkg::MUX_LAST) begin : g_mux
        localparam int LSB = ((g % FIELDS_PER_REG) * pfs_pkg::FIELD_STRIDE);
        if (g >= UPPER_FIRST) begin : g_up
          assign mode[g] = cfg.sel_upper[LSB +: pfs_pkg::MODE_W]; // see R5
        end else begin : g_mid
          assign mode[g] = cfg.sel_middle[LSB +: pfs_pkg::MODE_W]; // see R5
        end
      end else begin : g_fix
        assign mode[g] = pfs_pkg::MODE_PORT;
      end
      // one driver per pin bit: port, serial clock, or released
      logic port_sel;
      logic sck_sel;
      assign port_sel = (mode[g] == pfs_pkg::MODE_PORT); // see R2
      assign sck_sel = (g == pfs_pkg::PIN_SCK) && (mode[g] == pfs_pkg::MODE_SYNC_CLOCK); // see R4
      // receive or unsupported codes leave the pin undriven
      assign o_pin_out[g] = port_sel ? i_port_out[g] : (sck_sel ? i_sck_out : 1'b0);
      assign o_pin_oe[g] = port_sel ? cfg.direction[g] : (sck_sel ? i_sck_oe : 1'b0); // see R1
    end
  endgenerate

  // peripheral inputs, idle high when not routed
  always_comb begin
    o_rx_data = 1'b1;
    o_sck_in = 1'b1;
    if (mode[pfs_pkg::PIN_RX] == pfs_pkg::MODE_RECEIVE) begin
      o_rx_data = i_pin_sync[pfs_pkg::PIN_RX]; // see R3
    end
    if (mode[pfs_pkg::PIN_SCK] == pfs_pkg::MODE_SYNC_CLOCK) begin
      o_sck_in = i_pin_sync[pfs_pkg::PIN_SCK]; // see R4
    end
  end
endmodule : pfs_pin_mux

// ### src/pfs_top.sv
// port e pin function select register file and top level
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
// Operation
// R1 - direction bit per pin, zero means input
// R2 - mode code 000 selects plain port
// R3 - pin 11 field 14:12, 011 receive
// R4 - pin 6 field 10:8, 010 clock
// R5 - four fields per register, reserved gaps
// R6 - priority bits 3:0 for serial interrupts
// R7 - reserved bits read zero, write zero
module pfs_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // port data
  input wire logic [15:0] i_port_out,
  output logic [15:0] o_port_in,
  // pins
  input wire logic [15:0] i_pin,
  output logic [15:0] o_pin_out,
  output logic [15:0] o_pin_oe,
  // serial interface
  input wire logic i_sck_out,
  input wire logic i_sck_oe,
  output logic o_rx_data,
  output logic o_sck_in,
  // interrupt priority
  output logic [3:0] o_serial_prio,
  output logic [15:0] o_priority
);
  pfs_mode_if modes ();
  logic [15:0] dir_r, dir_nxt;
  logic [15:0] up_r, up_nxt;
  logic [15:0] mid_r, mid_nxt;
  logic [15:0] prio_r, prio_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] meta_r, sync_r;

  // register writes
  always_comb begin
    dir_nxt = dir_r;
    up_nxt = up_r;
    mid_nxt = mid_r;
    prio_nxt = prio_r;
    if (i_wr) begin
      unique case (i_addr)
        pfs_pkg::ADDR_DIRECTION: dir_nxt = i_wdata; // see R1
        pfs_pkg::ADDR_SEL_UPPER: up_nxt = i_wdata & pfs_pkg::SEL_WRITE_MASK; // see R7
        pfs_pkg::ADDR_SEL_MIDDLE: mid_nxt = i_wdata & pfs_pkg::SEL_WRITE_MASK; // see R7
        pfs_pkg::ADDR_PRIORITY: prio_nxt = i_wdata; // see R6
        default: ;
      endcase
    end
  end

  // register reads, unmapped read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        pfs_pkg::ADDR_DIRECTION: rdata_nxt = dir_r;
        pfs_pkg::ADDR_SEL_UPPER: rdata_nxt = up_r;
        pfs_pkg::ADDR_SEL_MIDDLE: rdata_nxt = mid_r;
        pfs_pkg::ADDR_PRIORITY: rdata_nxt = prio_r;
        pfs_pkg::ADDR_PIN_STATE: rdata_nxt = sync_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // register state
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_r <= pfs_pkg::RST_DIRECTION;
      up_r <= pfs_pkg::RST_SEL;
      mid_r <= pfs_pkg::RST_SEL;
      prio_r <= pfs_pkg::RST_PRIORITY;
      rdata_r <= 16'h0000;
    end else begin
      dir_r <= dir_nxt;
      up_r <= up_nxt;
      mid_r <= mid_nxt;
      prio_r <= prio_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pin synchroniser
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 16'h0000;
      sync_r <= 16'h0000;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
    end
  end

  assign modes.direction = dir_r;
  assign modes.sel_upper = up_r;
  assign modes.sel_middle = mid_r;
  assign o_rdata = rdata_r;
  assign o_port_in = sync_r;
  assign o_priority = prio_r;
  assign o_serial_prio = prio_r[pfs_pkg::SERIAL_PRIO_LSB +: pfs_pkg::PRIO_W]; // see R6

  // routing
  pfs_pin_mux u_mux (
    .cfg(modes.mux),
    .i_port_out(i_port_out),
    .i_pin_sync(sync_r),
    .i_sck_out(i_sck_out),
    .i_sck_oe(i_sck_oe),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .o_rx_data(o_rx_data),
    .o_sck_in(o_sck_in)
  );

  property p_reserved_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ((up_r | mid_r) & ~pfs_pkg::SEL_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // see R7

  property p_input_no_drive;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (!dir_r[0]) |-> !o_pin_oe[0];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven"); // see R1

  property p_port_mode;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (mid_r[10:8] == pfs_pkg::MODE_PORT) |-> (o_pin_oe[6] == dir_r[6] && o_pin_out[6] == i_port_out[6]);
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("port mode not routed"); // see R2

  property p_rx_route;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (up_r[14:12] == pfs_pkg::MODE_RECEIVE) |-> (o_rx_data == sync_r[11] && !o_pin_oe[11]);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("receive route wrong"); // see R3

  property p_sck_route;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (mid_r[10:8] == pfs_pkg::MODE_SYNC_CLOCK) |-> (o_pin_oe[6] == i_sck_oe && o_sck_in == sync_r[6]);
  endproperty
  a_sck_route: assert property (p_sck_route) else $error("clock route wrong"); // see R4

  property p_sel_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == pfs_pkg::ADDR_SEL_MIDDLE) |=> (mid_r == ($past(i_wdata) & pfs_pkg::SEL_WRITE_MASK));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost"); // see R5

  property p_prio;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == pfs_pkg::ADDR_PRIORITY) |=> (o_serial_prio == $past(i_wdata[3:0]));
  endproperty
  a_prio: assert property (p_prio) else $error("priority not taken"); // see R6

  property p_read;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == pfs_pkg::ADDR_DIRECTION && !$past(i_wr)) |=> (o_rdata == $past(dir_r));
  endproperty
  a_read: assert property (p_read) else $error("read data wrong"); // see R1

  // upper select write lands with reserved bits cleared
  property p_sel_write_up;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == pfs_pkg::ADDR_SEL_UPPER) |=> (up_r == ($past(i_wdata) & pfs_pkg::SEL_WRITE_MASK));
  endproperty
  a_sel_write_up: assert property (p_sel_write_up) else $error("upper select write lost"); // see R5

  // direction write reaches the enable of a fixed port pin
  property p_dir_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == pfs_pkg::ADDR_DIRECTION) |=>
        (o_pin_oe[pfs_pkg::PIN_COUNT-1] == $past(i_wdata[pfs_pkg::PIN_COUNT-1]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // see R1

  // read data stand only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_rd) |=> (o_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read"); // see R5

  // synchronised pin state readable
  property p_pin_state;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == pfs_pkg::ADDR_PIN_STATE) |=> (o_rdata == $past(sync_r));
  endproperty
  a_pin_state: assert property (p_pin_state) else $error("pin state read wrong"); // see R1

  // receive input rests high when pin 11 is not routed to it
  property p_rx_idle;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (up_r[pfs_pkg::PIN11_FIELD_LSB +: pfs_pkg::MODE_W] != pfs_pkg::MODE_RECEIVE) |-> o_rx_data;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive input not idle"); // see R3

  // clock input rests high when pin 6 is not routed to it
  property p_sck_idle;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (mid_r[pfs_pkg::PIN6_FIELD_LSB +: pfs_pkg::MODE_W] != pfs_pkg::MODE_SYNC_CLOCK) |-> o_sck_in;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock input not idle"); // see R4

  // pin 11 in port mode follows port data and direction
  property p_rx_port;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (up_r[pfs_pkg::PIN11_FIELD_LSB +: pfs_pkg::MODE_W] == pfs_pkg::MODE_PORT) |->
        (o_pin_oe[pfs_pkg::PIN_RX] == dir_r[pfs_pkg::PIN_RX] &&
          o_pin_out[pfs_pkg::PIN_RX] == i_port_out[pfs_pkg::PIN_RX]);
  endproperty
  a_rx_port: assert property (p_rx_port) else $error("pin 11 port mode wrong"); // see R2

  // pin 6 released under an unsupported code
  property p_sck_release;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (mid_r[pfs_pkg::PIN6_FIELD_LSB +: pfs_pkg::MODE_W] != pfs_pkg::MODE_PORT &&
        mid_r[pfs_pkg::PIN6_FIELD_LSB +: pfs_pkg::MODE_W] != pfs_pkg::MODE_SYNC_CLOCK) |->
        !o_pin_oe[pfs_pkg::PIN_SCK];
  endproperty
  a_sck_release: assert property (p_sck_release) else $error("pin 6 driven in unsupported mode"); // see R4

  // priority word changes only by a priority write
  property p_prio_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !(i_wr && i_addr == pfs_pkg::ADDR_PRIORITY) |=> $stable(o_priority);
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priority changed without write"); // see R6
endmodule : pfs_top

// ### tb/pfs_far_model.sv
// far side model: external pin levels and serial clock source
`timescale 1ns/100ps
module pfs_far_model (
  // clock
  input wire logic i_core_clk,
  // from block
  input wire logic [15:0] i_pin_out,
  input wire logic [15:0] i_pin_oe,
  // external level and serial run control
  input wire logic [15:0] i_ext,
  input wire logic i_sck_run,
  // to block
  output logic [15:0] o_pin,
  output logic o_sck_out,
  output logic o_sck_oe
);
  // wire level: block drive wins, else the external source
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
  assign o_sck_oe = i_sck_run;
  // clock toggles only while running, rests high
  always_ff @(posedge i_core_clk) begin
    o_sck_out <= i_sck_run ? ~o_sck_out : 1'b1;
  end
endmodule : pfs_far_model

// ### tb/pfs_top_tb_top.sv
// self-checking bench for the pin function select block
`timescale 1ns/100ps
module pfs_top_tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_port_out = 16'h0000;
  logic [15:0] ext = 16'h0000;
  logic sck_run = 1'b0;
  logic [15:0] o_rdata, o_port_in, i_pin, o_pin_out, o_pin_oe, o_priority;
  logic i_sck_out, i_sck_oe, o_rx_data, o_sck_in;
  logic [3:0] o_serial_prio;
  int err_total = 0;
  int n_tests = 0;
  // block under test and far side
  pfs_top uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_port_out(i_port_out), .o_port_in(o_port_in), .i_pin(i_pin),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .i_sck_out(i_sck_out), .i_sck_oe(i_sck_oe),
    .o_rx_data(o_rx_data), .o_sck_in(o_sck_in), .o_serial_prio(o_serial_prio), .o_priority(o_priority));
  pfs_far_model u_far (.i_core_clk(i_core_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext(ext),
    .i_sck_run(sck_run), .o_pin(i_pin), .o_sck_out(i_sck_out), .o_sck_oe(i_sck_oe));
  // 50 MHz clock
  always #10 i_core_clk = ~i_core_clk;
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // wait edges, then settle
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : wt
  // one write cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  // one read cycle, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, "read");
  endtask : rd
  task automatic t_reset();
    rd(pfs_pkg::ADDR_DIRECTION, 16'h0000);
    rd(pfs_pkg::ADDR_SEL_UPPER, 16'h0000);
    rd(pfs_pkg::ADDR_SEL_MIDDLE, 16'h0000);
    rd(pfs_pkg::ADDR_PRIORITY, 16'h0000);
    chk(o_pin_oe, 16'h0000, "reset oe");
    $display("test reset done");
  endtask : t_reset
  task automatic t_direction();
    @(posedge i_core_clk);
    ext <= 16'ha5a5;
    i_port_out <= 16'h3c3c;
    wr(pfs_pkg::ADDR_DIRECTION, 16'hffff);
    wt(3);
    chk(o_pin_oe, 16'hffff, "oe");
    chk(o_pin_out, 16'h3c3c, "port out");
    chk(o_port_in, 16'h3c3c, "port in");
    wr(pfs_pkg::ADDR_DIRECTION, 16'h0000);
    wt(3);
    chk(o_pin_oe, 16'h0000, "input oe");
    chk(o_port_in, 16'ha5a5, "pin in");
    rd(pfs_pkg::ADDR_PIN_STATE, 16'ha5a5);
    $display("test direction done");
  endtask : t_direction
  task automatic t_receive();
    wr(pfs_pkg::ADDR_DIRECTION, 16'h0800);
    wr(pfs_pkg::ADDR_SEL_UPPER, 16'h3000);
    ext <= 16'h0000;
    wt(4);
    chk(o_pin_oe[11], 1'b0, "rx oe");
    chk(o_rx_data, 1'b0, "rx low");
    @(posedge i_core_clk);
    ext <= 16'h0800;
    wt(4);
    chk(o_rx_data, 1'b1, "rx high");
    rd(pfs_pkg::ADDR_SEL_UPPER, 16'h3000);
    @(posedge i_core_clk);
    ext <= 16'h0000;
    wr(pfs_pkg::ADDR_SEL_UPPER, 16'h0000);
    wt(4);
    chk(o_rx_data, 1'b1, "rx idle");
    chk(o_pin_oe[11], 1'b1, "port oe");
    $display("test receive done");
  endtask : t_receive
  task automatic t_clock();
    wr(pfs_pkg::ADDR_SEL_MIDDLE, 16'h0200);
    sck_run <= 1'b1;
    wt(3);
    chk(o_pin_oe[6], 1'b1, "sck oe");
    chk(o_pin_out[6], i_sck_out, "sck out");
    chk(o_sck_in, i_sck_out, "sck in run");
    @(posedge i_core_clk);
    sck_run <= 1'b0;
    ext <= 16'h0000;
    wt(4);
    chk(o_sck_in, 1'b0, "sck in");
    rd(pfs_pkg::ADDR_SEL_MIDDLE, 16'h0200);
    $display("test clock done");
  endtask : t_clock
  task automatic t_reserved();
    wr(pfs_pkg::ADDR_SEL_UPPER, 16'hffff);
    wr(pfs_pkg::ADDR_SEL_MIDDLE, 16'hffff);
    rd(pfs_pkg::ADDR_SEL_UPPER, 16'h7777);
    rd(pfs_pkg::ADDR_SEL_MIDDLE, 16'h7777);
    rd(4'h6, 16'h0000);
    chk(o_pin_oe, 16'h0000, "released");
    $display("test reserved done");
  endtask : t_reserved
  task automatic t_prio();
    wr(pfs_pkg::ADDR_PRIORITY, 16'h000f);
    wt(1);
    chk(16'(o_serial_prio), 16'h000f, "prio");
    wr(pfs_pkg::ADDR_PRIORITY, 16'hf0f5);
    wt(1);
    chk(16'(o_serial_prio), 16'h0005, "prio low");
    chk(o_priority, 16'hf0f5, "prio word");
    rd(pfs_pkg::ADDR_PRIORITY, 16'hf0f5);
    $display("test priority done");
  endtask : t_prio
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_direction();
    t_receive();
    t_clock();
    t_reserved();
    t_prio();
    print_verdict();
  end
  // watchdog
  initial begin
    #20us;
    err_total++;
    print_verdict();
  end
endmodule : pfs_top_tb_top
